// file: host_port_pin_gpio_regs.sv
// Operation
// [R01] Data input bits read the sampled pin
// [R02] Writes to data input bits change nothing
// [R03] Data output pins drive the written value
// [R04] Data output bits read back written value
// [R05] Control direction bits apply only under GPIO
// [R06] Bits 14..11 steer byte enables 3..0
// [R07] Bit 10 ready pin, bit 8 interrupt
// [R08] Bits 7,6 access type, bit 5 halfword
// [R09] Bits 4..0 rw, strobes, select, addr strobe
// [R10] Software writes zero to direction bit 9
// [R11] Control input bits read the pin level
// [R12] Writes to control input bits are ignored
// [R13] Control output pins drive written value
// [R14] Control output bits read back written value
// [R15] Control value sets outputs, reports inputs
// [R16] Direction zero is input, one is output
// [R17] Direction counts only when group enabled
// [R18] Direction bits 31..15 read zero, ignore writes (control direction only; data direction stores all 32 bits)
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module host_port_pin_gpio_regs #(
    parameter int DATA_W = gpio_regs_pkg::DATA_PINS,
    parameter int CTRL_W = gpio_regs_pkg::CTRL_PINS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [31:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [DATA_W-1:0] host_data_pins_in_i,
    output logic [DATA_W-1:0] host_data_pins_out_o,
    output logic [DATA_W-1:0] host_data_pins_oe_o,
    input wire logic [CTRL_W-1:0] control_pins_in_i,
    output logic [CTRL_W-1:0] control_pins_out_o,
    output logic [CTRL_W-1:0] control_pins_oe_o,
    input wire logic [DATA_W-1:0] host_port_data_out_i,
    input wire logic [DATA_W-1:0] host_port_data_oe_i,
    input wire logic [CTRL_W-1:0] host_port_ctrl_out_i,
    input wire logic [CTRL_W-1:0] host_port_ctrl_oe_i
);

    function automatic gpio_regs_pkg::reg_sel_type reg_decode(
        input logic [31:0] addr
    );
        reg_decode = gpio_regs_pkg::SEL_NONE;
        case (addr)
            gpio_regs_pkg::PIN_ENABLE_ADDR: begin
                reg_decode = gpio_regs_pkg::SEL_ENABLE;
            end
            gpio_regs_pkg::DATA_DIR_ADDR: begin
                reg_decode = gpio_regs_pkg::SEL_DATA_DIR;
            end
            gpio_regs_pkg::DATA_VALUE_ADDR: begin
                reg_decode = gpio_regs_pkg::SEL_DATA_VALUE;
            end
            gpio_regs_pkg::CTRL_DIR_ADDR: begin
                reg_decode = gpio_regs_pkg::SEL_CTRL_DIR;
            end
            gpio_regs_pkg::CTRL_VALUE_ADDR: begin
                reg_decode = gpio_regs_pkg::SEL_CTRL_VALUE;
            end
            default: begin
                reg_decode = gpio_regs_pkg::SEL_NONE;
            end
        endcase
    endfunction : reg_decode

    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        for (int k = 0; k < 4; k++) begin
            strb_mask[k*8 +: 8] = {8{strb[k]}};
        end
    endfunction : strb_mask

    // One enable bit per byte of data pins
    function automatic logic [31:0] data_group_mask(input logic [12:0] en);
        for (int k = 0; k < 4; k++) begin
            data_group_mask[k*8 +: 8] =
                {8{en[gpio_regs_pkg::EN_DATA_BYTE0 + k]}};
        end
    endfunction : data_group_mask

    // Which enable bit hands each control pin over to GPIO
    function automatic logic [14:0] ctrl_group_mask(input logic [12:0] en);
        ctrl_group_mask = '0;
        ctrl_group_mask[gpio_regs_pkg::CP_BYTE_ENABLE_LSB +: 4] =
            {4{en[gpio_regs_pkg::EN_BYTE_ENABLE]}}; // [R06]
        ctrl_group_mask[gpio_regs_pkg::CP_READY] =
            en[gpio_regs_pkg::EN_READY]; // [R07]
        ctrl_group_mask[gpio_regs_pkg::CP_INTERRUPT] =
            en[gpio_regs_pkg::EN_INTERRUPT]; // [R07]
        ctrl_group_mask[gpio_regs_pkg::CP_ACCESS_TYPE0] =
            en[gpio_regs_pkg::EN_ACCESS_TYPE]; // [R08]
        ctrl_group_mask[gpio_regs_pkg::CP_ACCESS_TYPE1] =
            en[gpio_regs_pkg::EN_ACCESS_TYPE]; // [R08]
        ctrl_group_mask[gpio_regs_pkg::CP_HALFWORD] =
            en[gpio_regs_pkg::EN_HALFWORD]; // [R08]
        ctrl_group_mask[gpio_regs_pkg::CP_READ_WRITE] =
            en[gpio_regs_pkg::EN_STROBES]; // [R09]
        ctrl_group_mask[gpio_regs_pkg::CP_DATA_STROBE2] =
            en[gpio_regs_pkg::EN_STROBES]; // [R09]
        ctrl_group_mask[gpio_regs_pkg::CP_DATA_STROBE1] =
            en[gpio_regs_pkg::EN_STROBES]; // [R09]
        ctrl_group_mask[gpio_regs_pkg::CP_CHIP_SELECT] =
            en[gpio_regs_pkg::EN_STROBES]; // [R09]
        ctrl_group_mask[gpio_regs_pkg::CP_ADDR_STROBE] =
            en[gpio_regs_pkg::EN_ADDR_STROBE]; // [R09]
    endfunction : ctrl_group_mask

    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic aw_held_q, w_held_q;
    logic [31:0] awaddr_q, wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic [12:0] enable_q, enable_d;
    logic [31:0] data_dir_q, data_dir_d, data_val_q, data_val_d;
    logic [14:0] ctrl_dir_q, ctrl_dir_d, ctrl_val_q, ctrl_val_d;
    logic [31:0] data_out_q, data_oe_q;
    logic [14:0] ctrl_out_q, ctrl_oe_q;
    logic [31:0] data_level, data_gpio, data_in_mask, data_readback;
    logic [14:0] ctrl_level, ctrl_gpio, ctrl_in_mask, ctrl_readback;
    logic aw_hs, w_hs, ar_hs, wr_fire;
    logic [31:0] wmask, rd_value;
    gpio_regs_pkg::reg_sel_type wr_sel, rd_sel;

    pin_sync #(.WIDTH(DATA_W)) data_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(host_data_pins_in_i),
        .level_o(data_level)
    );

    pin_sync #(.WIDTH(CTRL_W)) ctrl_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(control_pins_in_i),
        .level_o(ctrl_level)
    );

    assign aw_hs = s_axi_awvalid_i && awready_q;
    assign w_hs = s_axi_wvalid_i && wready_q;
    assign ar_hs = s_axi_arvalid_i && arready_q;
    assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
    assign wr_sel = reg_decode(awaddr_q);
    assign rd_sel = reg_decode(s_axi_araddr_i);
    assign wmask = strb_mask(wstrb_q);

    assign data_gpio = data_group_mask(enable_q); // [R17]
    assign ctrl_gpio = ctrl_group_mask(enable_q); // [R05] [R17]
    // A zero direction bit makes an enabled pin an input
    assign data_in_mask = data_gpio & ~data_dir_q; // [R16]
    assign ctrl_in_mask = ctrl_gpio & ~ctrl_dir_q; // [R16]

    // Input bits read the pin, all others the stored value
    assign data_readback = (data_level & data_in_mask)
        | (data_val_q & ~data_in_mask); // [R01] [R04]
    assign ctrl_readback = (ctrl_level & ctrl_in_mask)
        | (ctrl_val_q & ~ctrl_in_mask); // [R11] [R14] [R15]

    // Stored bits of input pins are shielded from writes
    assign data_val_d = (wr_fire && wr_sel == gpio_regs_pkg::SEL_DATA_VALUE)
        ? (data_val_q & ~(wmask & ~data_in_mask))
          | (wdata_q & wmask & ~data_in_mask)
        : data_val_q; // [R02] [R03]
    assign ctrl_val_d = (wr_fire && wr_sel == gpio_regs_pkg::SEL_CTRL_VALUE)
        ? (ctrl_val_q & ~(wmask[14:0] & ~ctrl_in_mask))
          | (wdata_q[14:0] & wmask[14:0] & ~ctrl_in_mask)
        : ctrl_val_q; // [R12] [R13]
    // Only the low 15 bits exist; the rest drop writes and read zero
    assign ctrl_dir_d = (wr_fire && wr_sel == gpio_regs_pkg::SEL_CTRL_DIR)
        ? (ctrl_dir_q & ~wmask[14:0]) | (wdata_q[14:0] & wmask[14:0])
        : ctrl_dir_q; // [R05] [R18]
    assign data_dir_d = (wr_fire && wr_sel == gpio_regs_pkg::SEL_DATA_DIR)
        ? (data_dir_q & ~wmask) | (wdata_q & wmask)
        : data_dir_q;
    assign enable_d = (wr_fire && wr_sel == gpio_regs_pkg::SEL_ENABLE)
        ? (enable_q & ~wmask[12:0]) | (wdata_q[12:0] & wmask[12:0])
        : enable_q;

    assign rd_value =
        (rd_sel == gpio_regs_pkg::SEL_ENABLE) ? {19'h0_0000, enable_q} :
        (rd_sel == gpio_regs_pkg::SEL_DATA_DIR) ? data_dir_q :
        (rd_sel == gpio_regs_pkg::SEL_DATA_VALUE) ? data_readback :
        (rd_sel == gpio_regs_pkg::SEL_CTRL_DIR) ? {17'h0_0000, ctrl_dir_q} :
        (rd_sel == gpio_regs_pkg::SEL_CTRL_VALUE) ? {17'h0_0000, ctrl_readback} :
        32'h0000_0000; // [R18]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= gpio_regs_pkg::RESP_OKAY;
            awaddr_q <= 32'h0000_0000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            awready_q <= !aw_hs && !aw_held_q && !bvalid_q;
            wready_q <= !w_hs && !w_held_q && !bvalid_q;
            if (aw_hs) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr_i;
            end else if (wr_fire) begin
                aw_held_q <= 1'b0;
            end
            if (w_hs) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata_i;
                wstrb_q <= s_axi_wstrb_i;
            end else if (wr_fire) begin
                w_held_q <= 1'b0;
            end
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q <= (wr_sel == gpio_regs_pkg::SEL_NONE)
                    ? gpio_regs_pkg::RESP_SLVERR : gpio_regs_pkg::RESP_OKAY;
            end else if (s_axi_bready_i) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= gpio_regs_pkg::RESP_OKAY;
        end else begin
            arready_q <= !ar_hs && !rvalid_q && !arready_q ? 1'b1
                : (ar_hs ? 1'b0 : arready_q);
            if (ar_hs) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_value;
                rresp_q <= (rd_sel == gpio_regs_pkg::SEL_NONE)
                    ? gpio_regs_pkg::RESP_SLVERR : gpio_regs_pkg::RESP_OKAY;
            end else if (s_axi_rready_i) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_q <= gpio_regs_pkg::ENABLE_RESET;
            data_dir_q <= gpio_regs_pkg::DATA_DIR_RESET;
            data_val_q <= gpio_regs_pkg::DATA_VALUE_RESET;
            ctrl_dir_q <= gpio_regs_pkg::CTRL_DIR_RESET;
            ctrl_val_q <= gpio_regs_pkg::CTRL_VALUE_RESET;
        end else begin
            enable_q <= enable_d;
            data_dir_q <= data_dir_d;
            data_val_q <= data_val_d;
            ctrl_dir_q <= ctrl_dir_d;
            ctrl_val_q <= ctrl_val_d;
        end
    end

    // Pins leave through flops; host-port paths gain one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_out_q <= 32'h0000_0000;
            data_oe_q <= 32'h0000_0000;
            ctrl_out_q <= 15'h0000;
            ctrl_oe_q <= 15'h0000;
        end else begin
            data_out_q <= (data_gpio & data_val_q)
                | (~data_gpio & host_port_data_out_i); // [R03] [R17]
            data_oe_q <= (data_gpio & data_dir_q)
                | (~data_gpio & host_port_data_oe_i); // [R16] [R17]
            ctrl_out_q <= (ctrl_gpio & ctrl_val_q)
                | (~ctrl_gpio & host_port_ctrl_out_i); // [R13] [R15]
            ctrl_oe_q <= ((ctrl_gpio & ctrl_dir_q)
                | (~ctrl_gpio & host_port_ctrl_oe_i))
                & gpio_regs_pkg::CTRL_PIN_MASK; // [R16] [R17]
        end
    end

    assign s_axi_awready_o = awready_q;
    assign s_axi_wready_o = wready_q;
    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_bresp_o = bresp_q;
    assign s_axi_arready_o = arready_q;
    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rdata_o = rdata_q;
    assign s_axi_rresp_o = rresp_q;
    assign host_data_pins_out_o = data_out_q;
    assign host_data_pins_oe_o = data_oe_q;
    assign control_pins_out_o = ctrl_out_q;
    assign control_pins_oe_o = ctrl_oe_q;

    default clocking chk_cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_DATA_IN_READ: assert property ( // [R01]
        ar_hs && rd_sel == gpio_regs_pkg::SEL_DATA_VALUE |=>
        ((rdata_q ^ $past(data_level)) & $past(data_in_mask)) == 32'h0)
        else $error("data input bit read not the pin level");

    AST_DATA_IN_WRITE: assert property ( // [R02]
        ((data_val_q ^ $past(data_val_q)) & $past(data_in_mask)) == 32'h0)
        else $error("data input bit changed by a write");

    AST_DATA_OUT_PIN: assert property ( // [R03]
        ((host_data_pins_out_o ^ $past(data_val_q))
         & $past(data_gpio & data_dir_q)) == 32'h0)
        else $error("data output pin not driving stored value");

    AST_DATA_OUT_READ: assert property ( // [R04]
        ar_hs && rd_sel == gpio_regs_pkg::SEL_DATA_VALUE |=>
        ((rdata_q ^ $past(data_val_q)) & ~$past(data_in_mask)) == 32'h0)
        else $error("data output bit read back wrong");

    AST_CTRL_DIR_RSVD: assert property ( // [R18]
        ar_hs && rd_sel == gpio_regs_pkg::SEL_CTRL_DIR |=>
        rdata_q[31:15] == 17'h0_0000 && rresp_q == gpio_regs_pkg::RESP_OKAY)
        else $error("control direction reserved bits not zero");

    AST_CTRL_IN_WRITE: assert property ( // [R12]
        ((ctrl_val_q ^ $past(ctrl_val_q)) & $past(ctrl_in_mask)) == 15'h0)
        else $error("control input bit changed by a write");

    AST_CTRL_OUT_PIN: assert property ( // [R13]
        ((control_pins_out_o ^ $past(ctrl_val_q))
         & $past(ctrl_gpio & ctrl_dir_q)) == 15'h0)
        else $error("control output pin not driving stored value");

    AST_CTRL_IN_READ: assert property ( // [R11]
        ar_hs && rd_sel == gpio_regs_pkg::SEL_CTRL_VALUE |=>
        ((rdata_q[14:0] ^ $past(ctrl_level)) & $past(ctrl_in_mask)) == 15'h0)
        else $error("control input bit read not the pin level");

    AST_HOST_PORT_KEEP: assert property ( // [R17]
        !$past(rst_i) |-> ((host_data_pins_oe_o ^ $past(host_port_data_oe_i))
         & ~$past(data_gpio)) == 32'h0)
        else $error("disabled data pin left host-port control");

    AST_CTRL_DIR_OE: assert property ( // [R16]
        ((control_pins_oe_o ^ $past(ctrl_dir_q))
         & $past(ctrl_gpio) & gpio_regs_pkg::CTRL_PIN_MASK) == 15'h0)
        else $error("control pin enable does not follow direction");

    AST_WRITE_RESP: assert property (
        wr_fire |=> s_axi_bvalid_o ##0 !s_axi_awready_o)
        else $error("write response missing after address and data");

    COV_DATA_WRITE: cover property (
        wr_fire && wr_sel == gpio_regs_pkg::SEL_DATA_VALUE ##1 s_axi_bvalid_o);
    COV_CTRL_READ: cover property (
        ar_hs && rd_sel == gpio_regs_pkg::SEL_CTRL_VALUE ##1 s_axi_rvalid_o);
    COV_OUT_DRIVE: cover property (
        |(data_gpio & data_dir_q) ##1 |host_data_pins_oe_o);

endmodule : host_port_pin_gpio_regs
`default_nettype wire

// file: gpio_regs_pkg.sv
package gpio_regs_pkg;

    localparam int DATA_PINS = 32;
    localparam int CTRL_PINS = 15;
    localparam int ENABLE_BITS = 13;

    localparam logic [31:0] PIN_ENABLE_ADDR = 32'h4300_0008;
    localparam logic [31:0] DATA_DIR_ADDR = 32'h4300_0010;
    localparam logic [31:0] DATA_VALUE_ADDR = 32'h4300_0014;
    localparam logic [31:0] CTRL_DIR_ADDR = 32'h4300_0018;
    localparam logic [31:0] CTRL_VALUE_ADDR = 32'h4300_001C;

    localparam logic [12:0] ENABLE_RESET = 13'h0000;
    localparam logic [31:0] DATA_DIR_RESET = 32'h0000_0000;
    localparam logic [31:0] DATA_VALUE_RESET = 32'h0000_0000;
    localparam logic [14:0] CTRL_DIR_RESET = 15'h0000;
    localparam logic [14:0] CTRL_VALUE_RESET = 15'h0000;

    // Bit 9 of the control registers has no pin behind it
    localparam logic [14:0] CTRL_PIN_MASK = 15'h7DFF;

    // Pin group enable bits
    localparam int EN_DATA_BYTE0 = 7;
    localparam int EN_INTERRUPT = 6;
    localparam int EN_READY = 5;
    localparam int EN_HALFWORD = 4;
    localparam int EN_BYTE_ENABLE = 3;
    localparam int EN_ADDR_STROBE = 2;
    localparam int EN_ACCESS_TYPE = 1;
    localparam int EN_STROBES = 0;

    // Control pin positions
    localparam int CP_BYTE_ENABLE_LSB = 11;
    localparam int CP_READY = 10;
    localparam int CP_INTERRUPT = 8;
    localparam int CP_ACCESS_TYPE0 = 7;
    localparam int CP_ACCESS_TYPE1 = 6;
    localparam int CP_HALFWORD = 5;
    localparam int CP_READ_WRITE = 4;
    localparam int CP_DATA_STROBE2 = 3;
    localparam int CP_DATA_STROBE1 = 2;
    localparam int CP_CHIP_SELECT = 1;
    localparam int CP_ADDR_STROBE = 0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_ENABLE,
        SEL_DATA_DIR,
        SEL_DATA_VALUE,
        SEL_CTRL_DIR,
        SEL_CTRL_VALUE
    } reg_sel_type;

endpackage : gpio_regs_pkg

// file: pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o
);

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage1_q <= '0;
            stage2_q <= '0;
        end else begin
            stage1_q <= pin_i;
            stage2_q <= stage1_q;
        end
    end

    assign level_o = stage2_q;

endmodule : pin_sync
`default_nettype wire

// file: pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module pin_model #(
    parameter int W = 32
) (
    input wire logic [W-1:0] drive_i,
    input wire logic [W-1:0] oe_i,
    input wire logic [W-1:0] ext_i,
    output logic [W-1:0] level_o
);
    // The outside device drives every pin the block leaves alone,
    // so no pin floats and an input never reads a stale level
    assign level_o = (oe_i & drive_i) | (~oe_i & ext_i);
endmodule : pin_model
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    localparam logic [31:0] BAD_ADDR = 32'h4300_0020;
    localparam logic [1:0] OK = gpio_regs_pkg::RESP_OKAY;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, d_lvl, d_out, d_oe;
    logic [14:0] c_lvl, c_out, c_oe;
    logic [31:0] d_ext = 32'h0, c_ext = 32'h0, hp_do = 32'h0;
    logic [31:0] hp_doe = 32'h0, hp_co = 32'h0, hp_coe = 32'h0;
    logic [31:0] en, ddir, dval, cdir, cval, v, m, mc, t;
    logic [31:0] regs [5] = '{gpio_regs_pkg::PIN_ENABLE_ADDR,
        gpio_regs_pkg::DATA_DIR_ADDR, gpio_regs_pkg::DATA_VALUE_ADDR,
        gpio_regs_pkg::CTRL_DIR_ADDR, gpio_regs_pkg::CTRL_VALUE_ADDR};
    logic [15:0] seed = 16'hFC75;
    int num_errors = 0;
    int checks_done = 0;
    int wait_n = 0;

    always #10 clk_i = ~clk_i;

    host_port_pin_gpio_regs uut (
        .clk_i(clk_i), .rst_i(rst_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready),
        .host_data_pins_in_i(d_lvl), .host_data_pins_out_o(d_out),
        .host_data_pins_oe_o(d_oe), .control_pins_in_i(c_lvl),
        .control_pins_out_o(c_out), .control_pins_oe_o(c_oe),
        .host_port_data_out_i(hp_do), .host_port_data_oe_i(hp_doe),
        .host_port_ctrl_out_i(hp_co[14:0]),
        .host_port_ctrl_oe_i(hp_coe[14:0])
    );
    pin_model #(.W(32)) data_pins (.drive_i(d_out), .oe_i(d_oe),
        .ext_i(d_ext), .level_o(d_lvl));
    pin_model #(.W(15)) ctrl_pins (.drive_i(c_out), .oe_i(c_oe),
        .ext_i(c_ext[14:0]), .level_o(c_lvl));

    function automatic logic [31:0] rnd();
        logic [31:0] r;
        r = 32'h0;
        for (int i = 0; i < 32; i++) begin
            seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
            r = {r[30:0], seed[0]};
        end
        return r;
    endfunction : rnd

    // GPIO ownership of each data and control pin from the enable bits
    function automatic logic [31:0] dmask(input logic [31:0] e);
        return {{8{e[10]}}, {8{e[9]}}, {8{e[8]}}, {8{e[7]}}};
    endfunction : dmask

    function automatic logic [31:0] cmask(input logic [31:0] e);
        return {17'h0, {4{e[3]}}, e[5], 1'b0, e[6], e[1], e[1], e[4],
            {4{e[0]}}, e[2]};
    endfunction : cmask

    task automatic results();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    task automatic tick();
        wait_n++;
        if (wait_n > 200) begin
            num_errors++;
            $display("[ERR] %0t bus wait limit reached", $time);
            results();
        end
    endtask : tick

    task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp,
        input logic [31:0] msk);
        checks_done++;
        if (((got ^ exp) & msk) !== 32'h0) begin
            num_errors++;
            $display("[ERR] %0t data %h expected %h", $time, got, exp);
        end
    endtask : cmp_data

    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t response %h expected %h", $time, got, exp);
        end
    endtask : cmp_resp

    task automatic wr(input logic [31:0] a, input logic [31:0] d,
        input logic [3:0] s, input logic [1:0] er);
        logic ga;
        logic gw;
        ga = 1'b0;
        gw = 1'b0;
        wait_n = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ga && gw)) begin
            @(posedge clk_i);
            tick();
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                ga = 1'b1;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                gw = 1'b1;
            end
        end
        do begin
            @(posedge clk_i);
            tick();
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        cmp_resp(bresp, er);
        @(posedge clk_i);
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] exp,
        input logic [31:0] msk, input logic [1:0] er);
        wait_n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_i);
            tick();
        end while (arready !== 1'b1);
        arvalid <= 1'b0;
        do begin
            @(posedge clk_i);
            tick();
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        cmp_data(rdata, exp, msk);
        cmp_resp(rresp, er);
        @(posedge clk_i);
    endtask : rd

    initial begin
        {dval, cval} = 64'h0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (regs[i]) rd(regs[i], 32'h0, ALL, OK);
        // Unmapped place: refused both ways, and nothing is stored
        rd(BAD_ADDR, 32'h0, ALL, gpio_regs_pkg::RESP_SLVERR);
        wr(BAD_ADDR, rnd(), 4'hF, gpio_regs_pkg::RESP_SLVERR);
        for (int k = 0; k < 48; k++) begin
            d_ext <= rnd();
            c_ext <= rnd();
            hp_do <= rnd();
            hp_doe <= rnd();
            hp_co <= rnd();
            hp_coe <= rnd();
            t = rnd();
            en = (k < 3) ? 32'h0 : (k[0] ? 32'h1FFF : t & 32'h1FFF);
            wr(gpio_regs_pkg::PIN_ENABLE_ADDR, en, 4'hF, OK);
            ddir = rnd();
            wr(gpio_regs_pkg::DATA_DIR_ADDR, ddir, 4'hF, OK);
            v = rnd();
            t = rnd();
            m = {{8{t[3]}}, {8{t[2]}}, {8{t[1]}}, {8{t[0]}}};
            m = m & ~(dmask(en) & ~ddir);
            dval = (dval & ~m) | (v & m);
            wr(gpio_regs_pkg::DATA_VALUE_ADDR, v, t[3:0], OK);
            cdir = rnd() & 32'hFFFF_FDFF;
            wr(gpio_regs_pkg::CTRL_DIR_ADDR, cdir, 4'hF, OK);
            cdir = cdir & 32'h7FFF;
            v = rnd();
            mc = cmask(en) & ~cdir;
            cval = (cval & mc) | (v & ~mc);
            wr(gpio_regs_pkg::CTRL_VALUE_ADDR, v, 4'hF, OK);
            repeat (3) @(posedge clk_i);
            m = dmask(en);
            mc = cmask(en);
            cmp_data(d_oe, (m & ddir) | (~m & hp_doe), ALL);
            cmp_data(d_out, (m & dval) | (~m & hp_do), ~m | ddir);
            t = ((mc & cdir) | (~mc & hp_coe)) & 32'h7DFF;
            cmp_data({17'h0, c_oe}, t, ALL);
            t = (~mc | cdir) & 32'h7DFF;
            cmp_data({17'h0, c_out}, (mc & cval) | (~mc & hp_co), t);
            rd(gpio_regs_pkg::PIN_ENABLE_ADDR, en, ALL, OK);
            rd(gpio_regs_pkg::DATA_DIR_ADDR, ddir, ALL, OK);
            t = (m & ~ddir & d_ext) | (~(m & ~ddir) & dval);
            rd(gpio_regs_pkg::DATA_VALUE_ADDR, t, ALL, OK);
            rd(gpio_regs_pkg::CTRL_DIR_ADDR, cdir, ALL, OK);
            t = ((mc & ~cdir & c_ext) | (~(mc & ~cdir) & cval)) & 32'h7FFF;
            rd(gpio_regs_pkg::CTRL_VALUE_ADDR, t, ALL, OK);
        end
        // Reset in mid-run with busy host-port inputs: registers clear, pin enables follow the host port
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (regs[i]) rd(regs[i], 32'h0, ALL, OK);
        cmp_data(d_oe, hp_doe, ALL);
        cmp_data({17'h0, c_oe}, hp_coe & 32'h7DFF, ALL);
        results();
    end
endmodule : tb_top
`default_nettype wire
